// *** hdl/node_cfg_map.vh ***
// Purpose: constants for the node configuration set
// Assumes: plain Verilog-2005
// Notes:   ranges, reset values and encodings
`ifndef NODE_CFG_MAP_VH
`define NODE_CFG_MAP_VH
`define PASSIVE_PAIRS_MAX     5'd31
`define WAKE_REPEATS_MIN_TX   6'h02
`define LAST_MINISLOT_MAX     13'd7988
`define OFFSET_BEGIN_MIN      14'd7
`define OFFSET_BEGIN_MAX      14'd15999
`define HOST_ADJ_MAX          5'd28
`define OFFSET_LIMIT_MIN      15'd15
`define OFFSET_LIMIT_MAX      15'd16082
`define RATE_LIMIT_MIN        12'd3
`define RATE_LIMIT_MAX        12'd3846
`define DELAY_COMP_MIN        8'd4
`define DELAY_COMP_MAX        8'd211
`define INIT_OFFSET_MAX       8'd239
`define TICKS_CYCLE_MIN       21'd960
`define TICKS_CYCLE_MAX       21'd1280000
`define LISTEN_MIN            22'd1926
`define LISTEN_MAX            22'd2567692
`define CH_A                  2'b01
`define CH_B                  2'b10
`define ERR_BITS              4
`define ERR_SINK_TWO_SLOT     0
`define ERR_STARTUP_SYNC      1
`define ERR_TWO_SLOT_USE      2
`define ERR_WAKE_CHANNEL      3
`endif

// *** hdl/node_protocol_config_set.v ***
// Purpose: per-node configuration set and its behavioural effects
// Assumes: host holds cfg stable; events are one-cycle pulses
// Notes:   sync_lost / clock_error are same-clock pulses
`timescale 1ns/1ps
`default_nettype none
`include "node_cfg_map.vh"
module node_protocol_config_set
(
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        halt_on_clock_error_en,
  input  wire [4:0]  passive_recovery_pairs,
  input  wire        gateway_sink_sync,
  input  wire        local_clock_fallback,
  input  wire [10:0] primary_startup_slot_id,
  input  wire [10:0] secondary_startup_slot_id,
  input  wire        single_slot_mode_en,
  input  wire        slot_carries_startup,
  input  wire        slot_carries_sync,
  input  wire        dual_slot_coldstart,
  input  wire [12:0] last_dyn_tx_minislot,
  input  wire [5:0]  wake_symbol_repeats,
  input  wire [1:0]  wake_tx_channel,
  input  wire [1:0]  connected_channels,
  input  wire        netmgmt_early_refresh,
  input  wire [13:0] offset_phase_begin,
  input  wire [4:0]  host_offset_adjust,
  input  wire [4:0]  host_rate_adjust,
  input  wire        samples_per_tick,
  input  wire [14:0] offset_adjust_limit,
  input  wire [11:0] rate_adjust_limit,
  input  wire [7:0]  rx_delay_comp_a,
  input  wire [7:0]  rx_delay_comp_b,
  input  wire [7:0]  initial_tick_offset_a,
  input  wire [7:0]  initial_tick_offset_b,
  input  wire [20:0] ticks_per_cycle,
  input  wire [21:0] listen_timeout,
  input  wire        config_exit_req,
  input  wire        clock_error,
  input  wire        sync_lost,
  input  wire        pair_done,
  input  wire        pair_valid,
  input  wire        startup_done,
  input  wire        wake_send_enter,
  input  wire        wake_symbol_done,
  input  wire        static_end,
  input  wire        idle_time_end,
  input  wire [13:0] macrotick_count,
  input  wire [12:0] minislot_count,
  input  wire [1:0]  host_offset_cmd,
  input  wire [1:0]  host_rate_cmd,
  input  wire [15:0] offset_corr_in,
  input  wire [12:0] rate_corr_in,
  output reg         config_done_q,
  output reg  [3:0]  config_error_q,
  output reg  [1:0]  poc_state_q,
  output reg         local_clock_mode_q,
  output reg         single_slot_mode_q,
  output reg         primary_slot_used_q,
  output reg         secondary_slot_used_q,
  output wire        dyn_tx_allowed,
  output reg         wake_tx_active_q,
  output reg  [1:0]  wake_tx_lanes_q,
  output reg         netmgmt_update_q,
  output reg         offset_phase_q,
  output reg  [5:0]  host_offset_corr_q,
  output reg  [5:0]  host_rate_corr_q,
  output reg         dual_sample_q,
  output reg  [15:0] offset_corr_q,
  output reg  [12:0] rate_corr_q,
  output reg  [7:0]  rx_comp_a_q,
  output reg  [7:0]  rx_comp_b_q,
  output reg  [7:0]  init_off_a_q,
  output reg  [7:0]  init_off_b_q,
  output reg  [20:0] cycle_ticks_q,
  output reg  [21:0] listen_ticks_q
);
  localparam [1:0] ACTIVE_STATE  = 2'b00;
  localparam [1:0] PASSIVE_STATE = 2'b01;
  localparam [1:0] HALTED_STATE  = 2'b10;

  reg  [4:0]  pairs_q;
  reg  [5:0]  wake_left_q;
  reg  [3:0]  err_d;
  wire [15:0] off_mag;
  wire [12:0] rate_mag;

  // dependency check
  always @*
  begin
    err_d = 4'h0;
    err_d[`ERR_SINK_TWO_SLOT] = gateway_sink_sync & ~dual_slot_coldstart;
    err_d[`ERR_STARTUP_SYNC]  = slot_carries_startup & ~slot_carries_sync;
    err_d[`ERR_TWO_SLOT_USE]  = dual_slot_coldstart &
      ~(slot_carries_startup & slot_carries_sync);
    err_d[`ERR_WAKE_CHANNEL]  =
      ((wake_tx_channel != `CH_A) && (wake_tx_channel != `CH_B)) ||
      ((wake_tx_channel & connected_channels) == 2'b00);
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      config_done_q  <= 1'b0;
      config_error_q <= 4'h0;
    end
    else if (!config_done_q && config_exit_req)
    begin
      config_error_q <= err_d;
      config_done_q  <= (err_d == 4'h0);
    end
  end

  // fault state
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      poc_state_q        <= ACTIVE_STATE;
      local_clock_mode_q <= 1'b0;
      pairs_q            <= 5'd0;
    end
    else
    begin
      case (poc_state_q)
        ACTIVE_STATE:
        begin
          if (clock_error)
            poc_state_q <= halt_on_clock_error_en ?
                           HALTED_STATE : PASSIVE_STATE;
          pairs_q <= 5'd0;
        end
        PASSIVE_STATE:
        begin
          if (clock_error && halt_on_clock_error_en)
            poc_state_q <= HALTED_STATE;
          else if (pair_done)
          begin
            if (!pair_valid || clock_error)
              pairs_q <= 5'd0;
            else if (passive_recovery_pairs != 5'd0 &&
                     pairs_q + 5'd1 >= passive_recovery_pairs)
            begin
              poc_state_q <= ACTIVE_STATE;
              pairs_q     <= 5'd0;
            end
            else
              pairs_q <= pairs_q + 5'd1;
          end
        end
        HALTED_STATE:
          poc_state_q <= HALTED_STATE;
        default:
          poc_state_q <= HALTED_STATE;
      endcase
      if (sync_lost && gateway_sink_sync && poc_state_q != HALTED_STATE)
      begin
        if (local_clock_fallback)
          local_clock_mode_q <= 1'b1;
        else
          poc_state_q <= HALTED_STATE;
      end
    end
  end

  assign dyn_tx_allowed = config_done_q &&
                          minislot_count <= last_dyn_tx_minislot;

  assign off_mag  = offset_corr_in[15] ? ~offset_corr_in + 16'h0001
                                       : offset_corr_in;
  assign rate_mag = rate_corr_in[12] ? ~rate_corr_in + 13'h0001
                                     : rate_corr_in;

  // wakeup pattern
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      wake_tx_active_q <= 1'b0;
      wake_tx_lanes_q  <= 2'b00;
      wake_left_q      <= 6'h00;
    end
    else if (wake_send_enter && wake_symbol_repeats >= `WAKE_REPEATS_MIN_TX)
    begin
      wake_tx_active_q <= 1'b1;
      wake_left_q      <= wake_symbol_repeats;
      wake_tx_lanes_q  <= wake_tx_channel & connected_channels;
    end
    else if (wake_tx_active_q && wake_symbol_done)
    begin
      wake_left_q <= wake_left_q - 6'h01;
      if (wake_left_q == 6'h01)
        wake_tx_active_q <= 1'b0;
    end
  end

  // host adjustments
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      host_offset_corr_q <= 6'h00;
      host_rate_corr_q   <= 6'h00;
    end
    else
    begin
      case (host_offset_cmd)
        2'b01: host_offset_corr_q <= {1'b0, host_offset_adjust};
        2'b10: host_offset_corr_q <= ~{1'b0, host_offset_adjust} + 6'h01;
        default: host_offset_corr_q <= 6'h00;
      endcase
      case (host_rate_cmd)
        2'b01: host_rate_corr_q <= {1'b0, host_rate_adjust};
        2'b10: host_rate_corr_q <= ~{1'b0, host_rate_adjust} + 6'h01;
        default: host_rate_corr_q <= 6'h00;
      endcase
    end
  end

  // correction clamps
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      offset_corr_q <= 16'h0000;
      rate_corr_q   <= 13'h0000;
    end
    else
    begin
      if (off_mag > {1'b0, offset_adjust_limit})
        offset_corr_q <= offset_corr_in[15] ?
          ~{1'b0, offset_adjust_limit} + 16'h0001 :
          {1'b0, offset_adjust_limit};
      else
        offset_corr_q <= offset_corr_in;
      if (rate_mag > {1'b0, rate_adjust_limit})
        rate_corr_q <= rate_corr_in[12] ?
          ~{1'b0, rate_adjust_limit} + 13'h0001 :
          {1'b0, rate_adjust_limit};
      else
        rate_corr_q <= rate_corr_in;
    end
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      single_slot_mode_q    <= 1'b0;
      primary_slot_used_q   <= 1'b0;
      secondary_slot_used_q <= 1'b0;
      netmgmt_update_q      <= 1'b0;
      offset_phase_q        <= 1'b0;
      dual_sample_q         <= 1'b0;
      rx_comp_a_q           <= `DELAY_COMP_MIN;
      rx_comp_b_q           <= `DELAY_COMP_MIN;
      init_off_a_q          <= 8'h00;
      init_off_b_q          <= 8'h00;
      cycle_ticks_q         <= `TICKS_CYCLE_MIN;
      listen_ticks_q        <= `LISTEN_MIN;
    end
    else
    begin
      primary_slot_used_q   <= primary_startup_slot_id != 11'h000;
      secondary_slot_used_q <= dual_slot_coldstart &&
                               secondary_startup_slot_id != 11'h000;
      if (startup_done && single_slot_mode_en)
        single_slot_mode_q <= 1'b1;
      netmgmt_update_q <= netmgmt_early_refresh ? static_end
                                                : idle_time_end;
      offset_phase_q <= macrotick_count >= offset_phase_begin;
      dual_sample_q <= samples_per_tick;
      rx_comp_a_q    <= rx_delay_comp_a;
      rx_comp_b_q    <= rx_delay_comp_b;
      init_off_a_q   <= initial_tick_offset_a;
      init_off_b_q   <= initial_tick_offset_b;
      cycle_ticks_q  <= ticks_per_cycle;
      listen_ticks_q <= listen_timeout;
    end
  end
endmodule // node_protocol_config_set
`default_nettype wire

// *** verification/node_cfg_asserts.sv ***
// Purpose: port assertions for the node configuration set
// Assumes: one clock, synchronous active-high reset
// Notes:   host keeps the limits stable while running
`timescale 1ns/1ps
`default_nettype none
module node_cfg_asserts
(
  input wire logic        clock, sys_rst, halt_on_clock_error_en,
  input wire logic        gateway_sink_sync, local_clock_fallback,
  input wire logic        dual_slot_coldstart, netmgmt_early_refresh,
  input wire logic        config_exit_req, clock_error, sync_lost,
  input wire logic        wake_send_enter, static_end, idle_time_end,
  input wire logic        config_done_q, local_clock_mode_q,
  input wire logic        dyn_tx_allowed, wake_tx_active_q,
  input wire logic        netmgmt_update_q,
  input wire logic [3:0]  config_error_q,
  input wire logic [1:0]  poc_state_q,
  input wire logic [12:0] last_dyn_tx_minislot, minislot_count,
  input wire logic [5:0]  wake_symbol_repeats,
  input wire logic [14:0] offset_adjust_limit,
  input wire logic [15:0] offset_corr_in, offset_corr_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire signed [16:0] lim = {2'b00, offset_adjust_limit};
  wire signed [16:0] oin = {offset_corr_in[15], offset_corr_in};
  a_halt_on_err: assert property (
    clock_error && halt_on_clock_error_en |=> poc_state_q == 2'b10)
    else $error("no halt on clock error");
  a_passive_on_err: assert property (
    clock_error && !halt_on_clock_error_en && poc_state_q != 2'b10
    |=> poc_state_q == 2'b01) else $error("no passive on clock error");
  a_sink_fallback: assert property (
    sync_lost && gateway_sink_sync && local_clock_fallback
    |=> local_clock_mode_q) else $error("no local clock fallback");
  a_dyn_window: assert property (
    dyn_tx_allowed |-> minislot_count <= last_dyn_tx_minislot)
    else $error("dynamic tx past last minislot");
  a_wake_start: assert property (
    wake_send_enter && wake_symbol_repeats >= 6'h02 |=> wake_tx_active_q)
    else $error("wakeup pattern not started");
  a_wake_none: assert property (
    wake_send_enter && wake_symbol_repeats < 6'h02 && !wake_tx_active_q
    |=> !wake_tx_active_q) else $error("wakeup sent for 0 or 1");
  a_nm_source: assert property (
    netmgmt_update_q
    |-> $past(netmgmt_early_refresh ? static_end : idle_time_end))
    else $error("netmgmt refresh at wrong point");
  a_offset_clamp: assert property (
    oin > lim |=> offset_corr_q == lim[15:0])
    else $error("offset correction not clamped");
  a_cfg_refuse: assert property (
    config_exit_req && !config_done_q && gateway_sink_sync
    && !dual_slot_coldstart |=> !config_done_q && config_error_q[0])
    else $error("bad config accepted");
  c_recover: cover property (poc_state_q == 2'b01 ##1 poc_state_q == 2'b00);
  c_wake: cover property (wake_tx_active_q ##1 !wake_tx_active_q);
  c_done: cover property (config_done_q);
endmodule // node_cfg_asserts
bind node_protocol_config_set node_cfg_asserts chk_i (.*);
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: directed bench for the node configuration set
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   event pulses come from one vector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, sys_rst = 1, pair_valid = 0;
  logic halt_on_clock_error_en = 0, gateway_sink_sync = 0;
  logic local_clock_fallback = 1, single_slot_mode_en = 0;
  logic slot_carries_startup = 1, slot_carries_sync = 1;
  logic dual_slot_coldstart = 0, netmgmt_early_refresh = 1;
  logic samples_per_tick = 1;
  logic [4:0] passive_recovery_pairs = 5'h02;
  logic [4:0] host_offset_adjust = 5'h1C, host_rate_adjust = 5'h03;
  logic [10:0] primary_startup_slot_id = 11'h005;
  logic [10:0] secondary_startup_slot_id = 11'h000;
  logic [12:0] last_dyn_tx_minislot = 13'h1F34, minislot_count = 0;
  logic [5:0] wake_symbol_repeats = 6'h03;
  logic [1:0] wake_tx_channel = 2'h2, connected_channels = 2'h3;
  logic [1:0] host_offset_cmd = 0, host_rate_cmd = 0;
  logic [13:0] offset_phase_begin = 14'h0007, macrotick_count = 0;
  logic [14:0] offset_adjust_limit = 15'h000F;
  logic [11:0] rate_adjust_limit = 12'h003;
  logic [7:0] rx_delay_comp_a = 8'hD3, rx_delay_comp_b = 8'h2A;
  logic [7:0] initial_tick_offset_a = 8'hEF;
  logic [7:0] initial_tick_offset_b = 8'h7A;
  logic [20:0] ticks_per_cycle = 21'h138800;
  logic [21:0] listen_timeout = 22'h272E0C;
  logic [15:0] offset_corr_in = 0;
  logic [12:0] rate_corr_in = 0;
  logic [8:0] ev = 0;
  wire config_exit_req, clock_error, sync_lost, pair_done, startup_done;
  wire wake_send_enter, wake_symbol_done, static_end, idle_time_end;
  wire config_done_q, local_clock_mode_q, single_slot_mode_q;
  wire primary_slot_used_q, secondary_slot_used_q, dyn_tx_allowed;
  wire wake_tx_active_q, netmgmt_update_q, offset_phase_q, dual_sample_q;
  wire [3:0] config_error_q;
  wire [1:0] poc_state_q, wake_tx_lanes_q;
  wire [5:0] host_offset_corr_q, host_rate_corr_q;
  wire [15:0] offset_corr_q;
  wire [12:0] rate_corr_q;
  wire [7:0] rx_comp_a_q, rx_comp_b_q, init_off_a_q, init_off_b_q;
  wire [20:0] cycle_ticks_q;
  wire [21:0] listen_ticks_q;
  int err_count = 0, n_checks = 0, cyc = 0;
  assign {config_exit_req, clock_error, sync_lost, pair_done, startup_done,
          wake_send_enter, wake_symbol_done, static_end, idle_time_end} = ev;
  node_protocol_config_set uut (.*);
  initial forever #25 clock = ~clock;
  task chk(input string n, input logic [21:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %0h got %0h", n, e, g);
      err_count++;
    end
  endtask
  task fire(input logic [8:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 0;
    #1;
  endtask
  task pair(input logic v);
    @(posedge clock);
    pair_valid <= v;
    fire(9'h020);
  endtask
  task summarize();
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    #1 chk("rx_comp_a", 8'h04, rx_comp_a_q);
    chk("cycle", 21'h0003C0, cycle_ticks_q);
    chk("listen", 22'h000786, listen_ticks_q);
    fire(9'h000);
    chk("rx_comp_a", 8'hD3, rx_comp_a_q);
    chk("rx_comp_b", 8'h2A, rx_comp_b_q);
    chk("init_off_a", 8'hEF, init_off_a_q);
    chk("init_off_b", 8'h7A, init_off_b_q);
    chk("phase_early", 1'b0, offset_phase_q);
    chk("cycle", 21'h138800, cycle_ticks_q);
    chk("listen", 22'h272E0C, listen_ticks_q);
    chk("samples", 1'b1, dual_sample_q);
    @(posedge clock);
    gateway_sink_sync <= 1;
    connected_channels <= 2'h1;
    fire(9'h100);
    chk("cfg_done", 1'b0, config_done_q);
    chk("cfg_err", 4'h9, config_error_q);
    @(posedge clock);
    dual_slot_coldstart <= 1;
    connected_channels <= 2'h3;
    slot_carries_sync <= 0;
    fire(9'h100);
    chk("cfg_err", 4'h6, config_error_q);
    @(posedge clock);
    slot_carries_sync <= 1;
    fire(9'h100);
    chk("cfg_done", 1'b1, config_done_q);
    chk("cfg_err", 4'h0, config_error_q);
    chk("slot1", 1'b1, primary_slot_used_q);
    chk("slot2", 1'b0, secondary_slot_used_q);
    fire(9'h008);
    chk("wake_on", 1'b1, wake_tx_active_q);
    chk("wake_lane", 2'h2, wake_tx_lanes_q);
    repeat (2) fire(9'h004);
    chk("wake_mid", 1'b1, wake_tx_active_q);
    fire(9'h004);
    chk("wake_off", 1'b0, wake_tx_active_q);
    @(posedge clock);
    wake_symbol_repeats <= 6'h01;
    fire(9'h008);
    chk("wake_none", 1'b0, wake_tx_active_q);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      netmgmt_early_refresh <= !i[0];
      fire(9'h002);
      chk("nm_static", !i[0], netmgmt_update_q);
      fire(9'h001);
      chk("nm_idle", i[0], netmgmt_update_q);
    end
    @(posedge clock);
    minislot_count <= 13'h1F34;
    #1 chk("dyn_last", 1'b1, dyn_tx_allowed);
    @(posedge clock);
    minislot_count <= 13'h1F35;
    #1 chk("dyn_over", 1'b0, dyn_tx_allowed);
    @(posedge clock);
    offset_corr_in <= 16'h0064;
    rate_corr_in <= 13'h1FF0;
    host_offset_cmd <= 2'h2;
    host_rate_cmd <= 2'h1;
    macrotick_count <= 14'h0007;
    single_slot_mode_en <= 1;
    fire(9'h010);
    chk("off_clamp", 16'h000F, offset_corr_q);
    chk("rate_clamp", 13'h1FFD, rate_corr_q);
    chk("host_off", 6'h24, host_offset_corr_q);
    chk("host_rate", 6'h03, host_rate_corr_q);
    chk("phase", 1'b1, offset_phase_q);
    chk("key_only", 1'b1, single_slot_mode_q);
    @(posedge clock);
    offset_corr_in <= 16'h8000;
    secondary_startup_slot_id <= 11'h009;
    fire(9'h000);
    chk("off_neg", 16'hFFF1, offset_corr_q);
    chk("slot2_on", 1'b1, secondary_slot_used_q);
    fire(9'h080);
    chk("passive", 2'h1, poc_state_q);
    pair(1);
    pair(0);
    pair(1);
    chk("still_passive", 2'h1, poc_state_q);
    pair(1);
    chk("active", 2'h0, poc_state_q);
    fire(9'h040);
    chk("fallback", 1'b1, local_clock_mode_q);
    @(posedge clock);
    halt_on_clock_error_en <= 1;
    fire(9'h080);
    chk("halted", 2'h2, poc_state_q);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
